/* pkg/vbi_flags_pkg.sv */
/*
 holds the constants and types shared by the valid/field flag block.
 assumes one 25 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// R01 - in header time mode serial bytes 5 to 8 carry header row bytes 42 to 45, each bit-reversed.
// R02 - the active-low data-valid output goes low in the line where valid data for the mode arrives.
// R03 - data-valid returns high at the start of line 16 in video-programme mode, or at the next field otherwise.
// R04 - data-valid is forced high when a serial read ends with a withheld acknowledge before stop.
// R05 - the first-field output rises at the beginning of the first field of each frame.
// R06 - the first-field output falls at the beginning of the second field and stays low through it.
// R07 - while test mode is high both outputs copy the address-select input.
// R08 - a serial read hands out the stored bytes from byte 1 onward, each acknowledge advancing one byte until byte 8, where the index holds.
package vbi_flags_pkg;

	typedef enum logic [1:0] {
		MODE_VPS,
		MODE_PDC_F2,
		MODE_PDC_F1,
		MODE_HDR_TIME
	} mode_t;

	localparam int          CLK_HZ        = 25000000;
	localparam int          NUM_BYTES     = 8;
	localparam logic [9:0]  VPS_LINE      = 10'h010;
	localparam logic [5:0]  HDR_FIRST_COL = 6'h26;
	localparam logic [5:0]  HDR_LAST_COL  = 6'h2D;
	localparam logic [2:0]  IDX_LAST      = 3'h7;
	localparam logic [2:0]  IDX_RST       = 3'h0;
	localparam logic        DV_N_RST      = 1'b1;
	localparam logic        FF_RST        = 1'b0;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

endpackage

/* core/pin_sync3.sv */
/*
 holds a three-stage pin synchroniser with agreement filter.
 assumes the pin is asynchronous to i_clk; output changes when stages two and three agree.
*/
`timescale 1ns/1ns
module pin_sync3 (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_ce,
	input  wire logic i_pin,
	output logic      o_level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;

	sync_t s_r;
	sync_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = i_pin;
		// first stage feeds only the second
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.lvl = s_r.s3;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_r <= '0;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.lvl;
endmodule

/* core/vbi_flags.sv */
/*
 holds the data-valid and first-field flag logic and the header time read-out store.
 assumes video timing strobes and serial-engine strobes come from logic on i_clk;
 the test-mode and address-select pins are asynchronous.
*/
`timescale 1ns/1ns
module vbi_flags (
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_ce,
	input  wire vbi_flags_pkg::mode_t i_mode,
	input  wire logic                 i_line_start,
	input  wire logic [9:0]           i_line_num,
	input  wire logic                 i_field_start,
	input  wire logic                 i_first_field,
	input  wire logic                 i_data_ok,
	input  wire logic                 i_hdr_wr,
	input  wire logic [5:0]           i_hdr_col,
	input  wire logic [7:0]           i_hdr_data,
	input  wire logic                 i_rd_start,
	input  wire logic                 i_rd_ack,
	input  wire logic                 i_rd_nack_stop,
	input  wire logic                 i_test_mode_input,
	input  wire logic                 i_address_select_input,
	output logic                      o_data_valid_n,
	output logic                      o_first_field_flag,
	output logic [7:0]                o_rd_byte
);
	typedef struct packed {
		logic [7:0][7:0] store;
		logic [2:0]      idx;
		logic [7:0]      rd_byte;
		logic            dv_norm;
		logic            ff_norm;
		logic            dv_n;
		logic            ff;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic   tm;
	logic   sel;

	// received bit 0 goes out first, i.e. in serial bit 7
	function automatic logic [7:0] bit_rev(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	function automatic logic is_hdr_col(input logic [5:0] c);
		return (c >= vbi_flags_pkg::HDR_FIRST_COL) && (c <= vbi_flags_pkg::HDR_LAST_COL);
	endfunction

	pin_sync3 u_sync_tm (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_pin     (i_test_mode_input),
		.o_level   (tm)
	);

	pin_sync3 u_sync_sel (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_pin     (i_address_select_input),
		.o_level   (sel)
	);

	logic vps16;
	logic pdc_field;
	logic [2:0] col_idx;
	assign vps16     = (i_mode == vbi_flags_pkg::MODE_VPS) && i_line_start
		&& (i_line_num == vbi_flags_pkg::VPS_LINE);
	assign pdc_field = (i_mode != vbi_flags_pkg::MODE_VPS) && i_field_start;
	assign col_idx   = 3'(i_hdr_col - vbi_flags_pkg::HDR_FIRST_COL);

	always_comb begin
		s_nxt = s_r;
		if (i_hdr_wr && (i_mode == vbi_flags_pkg::MODE_HDR_TIME) && is_hdr_col(i_hdr_col)) begin
			s_nxt.store[col_idx] = i_hdr_data; // R01
		end
		if (i_rd_start) begin
			s_nxt.idx = vbi_flags_pkg::IDX_RST; // R08
		end else if (i_rd_ack && (s_r.idx != vbi_flags_pkg::IDX_LAST)) begin
			s_nxt.idx = s_r.idx + 3'h1; // R08
		end
		// byte shown is taken from the already-updated store and index
		s_nxt.rd_byte = bit_rev(s_nxt.store[s_nxt.idx]); // R01
		// a stop-ending read wins over a fresh data arrival in the same cycle
		if (i_rd_nack_stop) begin
			s_nxt.dv_norm = 1'b1; // R04
		end else if (vps16 || pdc_field) begin
			s_nxt.dv_norm = 1'b1; // R03
		end else if (i_data_ok) begin
			s_nxt.dv_norm = 1'b0; // R02
		end
		if (i_field_start) begin
			s_nxt.ff_norm = i_first_field; // R05 R06
		end
		// normal state keeps running under test mode, so leaving test is seamless
		if (tm) begin
			s_nxt.dv_n = sel; // R07
			s_nxt.ff   = sel; // R07
		end else begin
			s_nxt.dv_n = s_nxt.dv_norm;
			s_nxt.ff   = s_nxt.ff_norm;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_r         <= '0;
			s_r.idx     <= vbi_flags_pkg::IDX_RST;
			s_r.rd_byte <= vbi_flags_pkg::BYTE_RST;
			s_r.dv_norm <= vbi_flags_pkg::DV_N_RST;
			s_r.ff_norm <= vbi_flags_pkg::FF_RST;
			s_r.dv_n    <= vbi_flags_pkg::DV_N_RST;
			s_r.ff      <= vbi_flags_pkg::FF_RST;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_data_valid_n     = s_r.dv_n;
	assign o_first_field_flag = s_r.ff;
	assign o_rd_byte          = s_r.rd_byte;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// any of bytes 5 to 8 written while the read index rests on that same byte
	sequence s_hdr_hi;
		i_ce && i_hdr_wr && (i_mode == vbi_flags_pkg::MODE_HDR_TIME) && (i_hdr_col >= 6'h2A)
			&& is_hdr_col(i_hdr_col);
	endsequence

	sequence s_park_same;
		i_ce && (s_r.idx == 3'($past(i_hdr_col) - vbi_flags_pkg::HDR_FIRST_COL))
			&& !i_rd_start && !i_rd_ack && !i_hdr_wr;
	endsequence

	property p_hdr_map;
		s_hdr_hi ##1 s_park_same |=> o_rd_byte == bit_rev($past(i_hdr_data, 2));
	endproperty
	a_hdr_map: assert property (p_hdr_map) else $error("header byte 42 not read as byte 5"); // R01

	property p_dv_low;
		i_ce && !tm && i_data_ok && !i_rd_nack_stop && !vps16 && !pdc_field
			|=> !o_data_valid_n;
	endproperty
	a_dv_low: assert property (p_dv_low) else $error("data valid not driven low"); // R02

	property p_dv_vps_high;
		i_ce && !tm && vps16 |=> o_data_valid_n;
	endproperty
	a_dv_vps_high: assert property (p_dv_vps_high) else $error("data valid not high at line 16"); // R03

	property p_dv_field_high;
		i_ce && !tm && pdc_field ##1 !i_ce [*2] |-> o_data_valid_n;
	endproperty
	a_dv_field_high: assert property (p_dv_field_high) else $error("data valid not high at field"); // R03

	property p_dv_nack;
		i_ce && !tm && i_rd_nack_stop |=> o_data_valid_n;
	endproperty
	a_dv_nack: assert property (p_dv_nack) else $error("data valid not forced high on stop"); // R04

	property p_ff_rise;
		i_ce && !tm && i_field_start && i_first_field |=> o_first_field_flag;
	endproperty
	a_ff_rise: assert property (p_ff_rise) else $error("first field flag not raised"); // R05

	property p_ff_hold;
		i_ce && !tm && i_field_start && !i_first_field
			##1 (!i_field_start && !tm) [*3] |=> !o_first_field_flag;
	endproperty
	a_ff_hold: assert property (p_ff_hold) else $error("first field flag not low in field two"); // R06

	property p_test_copy;
		i_ce && tm |=> (o_data_valid_n == $past(sel)) && (o_first_field_flag == $past(sel));
	endproperty
	a_test_copy: assert property (p_test_copy) else $error("test mode copy failed"); // R07

	property p_rd_start;
		i_ce && i_rd_start |=> s_r.idx == 3'h0;
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("read did not begin at byte 1"); // R08

	property p_rd_advance;
		i_ce && i_rd_ack && !i_rd_start && (s_r.idx != 3'h7)
			|=> s_r.idx == $past(s_r.idx) + 3'h1;
	endproperty
	a_rd_advance: assert property (p_rd_advance) else $error("ack did not advance byte"); // R08

	property p_freeze;
		!i_ce |=> $stable(s_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule

/* test/rd_master.sv */
/*
 serial master model: start, seven acknowledged bytes, then nack-stop.
 assumes the block samples the strobes at the rising edge of i_clk.
*/
`timescale 1ns/1ns
module rd_master (
	input  wire logic i_clk,
	input  wire logic i_go,
	input  wire logic i_slow,
	output logic      o_rd_start,
	output logic      o_rd_ack,
	output logic      o_rd_nack_stop,
	output logic      o_busy
);
	// one process drives every output, so each has a single driver
	initial begin
		{o_rd_start, o_rd_ack, o_rd_nack_stop, o_busy} = 4'h0;
		// prompt mode holds ack high so bytes advance back to back
		forever begin
			@(posedge i_go);
			o_busy = 1'b1;
			@(negedge i_clk) o_rd_start = 1'b1;
			@(negedge i_clk) o_rd_start = 1'b0;
			repeat (7) begin
				@(negedge i_clk) o_rd_ack = 1'b1;
				if (i_slow) begin
					@(negedge i_clk) o_rd_ack = 1'b0;
					repeat (2) @(negedge i_clk);
				end
			end
			@(negedge i_clk) {o_rd_ack, o_rd_nack_stop} = 2'b01;
			@(negedge i_clk) o_rd_nack_stop = 1'b0;
			o_busy = 1'b0;
		end
	end
endmodule

/* test/vbi_valid_field_flags_tb_top.sv */
/*
 bench for the flag block: header rows and read-out, then flag cases by hand.
 assumes rd_master strobes the read port; the bench drives i_ce and drops it once.
*/
`timescale 1ns/1ns
module vbi_valid_field_flags_tb_top;
	typedef struct packed {logic [5:0] col; logic [7:0] dat;} row_t;
	logic                 clk = 1'b0, rst = 1'b1, ls = 1'b0, fs = 1'b0, f1 = 1'b0;
	logic                 ok = 1'b0, wr = 1'b0, tm = 1'b0, sel = 1'b0, go = 1'b0, slow = 1'b0;
	logic                 rs, ra, rn, busy, dv_n, ff, act = 1'b0, ce = 1'b1;
	logic [9:0]           ln = 10'h000;
	logic [5:0]           col = 6'h00;
	logic [7:0]           dat = 8'h00, rb, mem [8];
	logic [2:0]           idx = 3'h0;
	vbi_flags_pkg::mode_t mode = vbi_flags_pkg::MODE_HDR_TIME;
	int                   fail_count = 0, compares = 0, n;
	row_t                 rows [8] = '{{6'h26, 8'h01}, {6'h27, 8'h80}, {6'h28, 8'h3C},
		{6'h29, 8'hA5}, {6'h2A, 8'h12}, {6'h2B, 8'hF0}, {6'h2C, 8'h6E}, {6'h2D, 8'hC3}};
	always #20 clk = ~clk;
	vbi_flags dut_u (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_mode(mode),
		.i_line_start(ls), .i_line_num(ln), .i_field_start(fs), .i_first_field(f1),
		.i_data_ok(ok), .i_hdr_wr(wr), .i_hdr_col(col), .i_hdr_data(dat), .i_rd_start(rs),
		.i_rd_ack(ra), .i_rd_nack_stop(rn), .i_test_mode_input(tm),
		.i_address_select_input(sel), .o_data_valid_n(dv_n), .o_first_field_flag(ff),
		.o_rd_byte(rb));
	rd_master pm_u (.i_clk(clk), .i_go(go), .i_slow(slow), .o_rd_start(rs), .o_rd_ack(ra),
		.o_rd_nack_stop(rn), .o_busy(busy));
	function automatic logic [7:0] rev(input logic [7:0] d);
		return {<<{d}};
	endfunction
	task final_report;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task ev(input logic [3:0] s);
		@(negedge clk);
		{ls, fs, ok, wr} = s;
		@(negedge clk);
		{ls, fs, ok, wr} = 4'h0;
	endtask
	task rd(input logic s);
		slow = s;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		for (n = 0; n < 100 && busy !== 1'b0; n++)
			@(negedge clk);
		if (n == 100) begin
			fail_count++;
			final_report;
		end
	endtask
	// reference index follows the master's strobes, saturating at byte 8
	always @(posedge clk) begin
		act <= rs ? 1'b1 : (rn ? 1'b0 : act);
		if (rs)
			idx <= 3'h0;
		else if (ra && idx != 3'h7)
			idx <= idx + 3'h1;
	end
	always @(negedge clk)
		if (act)
			chk(rb, rev(mem[idx]));
	initial begin
		repeat (4) @(negedge clk);
		chk(rb, 8'h00);
		chk({7'h0, dv_n}, 8'h01);
		chk({7'h0, ff}, 8'h00);
		rst = 1'b0;
		foreach (rows[i]) begin
			col = rows[i].col;
			dat = rows[i].dat;
			mem[i] = rows[i].dat;
			ev(4'h1);
		end
		rd(1'b0);
		rd(1'b1);
		// index rests on byte 8, so a fresh column 45 shows at once
		col = 6'h2D;
		dat = 8'h5A;
		mem[7] = 8'h5A;
		ev(4'h1);
		chk(rb, rev(8'h5A));
		mode = vbi_flags_pkg::MODE_VPS;
		ev(4'h2);
		chk({7'h0, dv_n}, 8'h00);
		ln = 10'h00F;
		ev(4'h8);
		chk({7'h0, dv_n}, 8'h00);
		ln = 10'h010;
		ev(4'h8);
		chk({7'h0, dv_n}, 8'h01);
		mode = vbi_flags_pkg::MODE_PDC_F2;
		ev(4'h2);
		chk({7'h0, dv_n}, 8'h00);
		f1 = 1'b1;
		ev(4'h4);
		chk({7'h0, dv_n}, 8'h01);
		chk({7'h0, ff}, 8'h01);
		f1 = 1'b0;
		ev(4'h4);
		chk({7'h0, ff}, 8'h00);
		ev(4'h2);
		chk({7'h0, dv_n}, 8'h00);
		ev(4'h4);
		ce = 1'b0;
		// data arriving while the enable is low is dropped, not queued
		ev(4'h2);
		chk({7'h0, dv_n}, 8'h01);
		ce = 1'b1;
		@(negedge clk);
		chk({7'h0, dv_n}, 8'h01);
		mode = vbi_flags_pkg::MODE_PDC_F1;
		repeat (2) begin
			ev(4'h2);
			chk({7'h0, dv_n}, 8'h00);
			rd(1'b0);
			chk({7'h0, dv_n}, 8'h01);
			mode = vbi_flags_pkg::MODE_HDR_TIME;
		end
		tm = 1'b1;
		repeat (8) @(negedge clk);
		chk({7'h0, dv_n}, 8'h00);
		sel = 1'b1;
		repeat (8) @(negedge clk);
		chk({7'h0, ff}, 8'h01);
		chk({7'h0, dv_n}, 8'h01);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk(rb, 8'h00);
		chk({7'h0, dv_n}, 8'h01);
		chk({7'h0, ff}, 8'h00);
		rst = 1'b0;
		// test pin is still high, but the pin filter restarts from zero
		repeat (2) begin
			@(negedge clk);
			chk({7'h0, dv_n}, 8'h01);
			chk({7'h0, ff}, 8'h00);
		end
		repeat (8) @(negedge clk);
		chk({7'h0, ff}, 8'h01);
		final_report;
	end
endmodule
